// [logic/cit_regs.svh]
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

// ==========================================================================
// Program byte counts
`define CIT_B0 2'h0
`define CIT_B1 2'h1
`define CIT_B2 2'h2
`define CIT_B3 2'h3

// ==========================================================================
// Execution times in system clocks
`define CIT_C0 4'h0
`define CIT_C1 4'h1
`define CIT_C2 4'h2
`define CIT_C3 4'h3
`define CIT_C4 4'h4
`define CIT_C5 4'h5
`define CIT_C8 4'h8
`define CIT_MAX_CYC 4'h8

// ==========================================================================
// Status word flag update mask: {carry, aux carry, overflow}
`define CIT_FL_NONE 3'h0
`define CIT_FL_CY 3'h4
`define CIT_FL_CYOV 3'h5
`define CIT_FL_ALL 3'h7

// ==========================================================================
// Register file address layout
`define CIT_ADDR_PAD 3'h0
`define CIT_RI_PAD 2'h0
`define CIT_ADDR_RST 8'h00

`endif

// [logic/cit_pkg.sv]
package cit_pkg;

  // ========================================================================
  // Operand addressing modes
  typedef enum logic [2:0] {
    CIT_AM_IMPLIED  = 3'b000,
    CIT_AM_REG      = 3'b001,
    CIT_AM_DIRECT   = 3'b010,
    CIT_AM_INDIRECT = 3'b011,
    CIT_AM_IMM      = 3'b100,
    CIT_AM_BIT      = 3'b101,
    CIT_AM_CODE     = 3'b110,
    CIT_AM_BRANCH   = 3'b111
  } cit_amode_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic {
    CIT_ST_IDLE = 1'b0,
    CIT_ST_EXEC = 1'b1
  } cit_state_t;

  // ========================================================================
  // One decoded instruction
  typedef struct packed {
    cit_amode_t amode;
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic cond;
    logic [2:0] flags;
    logic illegal;
  } cit_dec_t;

endpackage : cit_pkg

// [logic/cit_dec_if.sv]
`timescale 1ns/10ps

interface cit_dec_if;
  import cit_pkg::*;

  logic [7:0] opcode;
  cit_dec_t dec;

  modport decoder (input opcode, output dec);
  modport sequencer (output opcode, input dec);
endinterface : cit_dec_if

// [logic/cit_decode.sv]
`timescale 1ns/10ps
`include "cit_regs.svh"

module cit_decode (
  cit_dec_if.decoder dif // Opcode in, decoded fields out
);
  import cit_pkg::*;

  function automatic cit_dec_t mk(input cit_amode_t m, input logic [1:0] b,
                                  input logic [3:0] c, input logic k,
                                  input logic [2:0] f);
    cit_dec_t d;
    d.amode = m;
    d.bytes = b;
    d.cycles = c;
    d.cond = k;
    d.flags = f;
    d.illegal = 1'b0;
    return d;
  endfunction : mk

  // ========================================================================
  // Opcode map; cycles is the not-taken time for conditional forms
  always_comb begin
    dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
    casez (dif.opcode)
      8'h00: dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
      8'h?1: dif.dec = mk(CIT_AM_BRANCH, `CIT_B2, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'h02, 8'h12: dif.dec = mk(CIT_AM_BRANCH, `CIT_B3, `CIT_C4, 1'b0, `CIT_FL_NONE);
      8'h22, 8'h32: dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C5, 1'b0, `CIT_FL_NONE);
      8'h10, 8'h20, 8'h30:
        dif.dec = mk(CIT_AM_BIT, `CIT_B3, `CIT_C3, 1'b1, `CIT_FL_NONE);
      8'h40, 8'h50, 8'h60, 8'h70:
        dif.dec = mk(CIT_AM_BRANCH, `CIT_B2, `CIT_C2, 1'b1, `CIT_FL_NONE);
      8'h80: dif.dec = mk(CIT_AM_BRANCH, `CIT_B2, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'h90: dif.dec = mk(CIT_AM_IMM, `CIT_B3, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'hA0, 8'hB0, 8'h72, 8'h82, 8'hA2:
        dif.dec = mk(CIT_AM_BIT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_CY);
      8'h92, 8'hB2, 8'hC2, 8'hD2:
        dif.dec = mk(CIT_AM_BIT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'hC0, 8'hD0: dif.dec = mk(CIT_AM_DIRECT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'hE0, 8'hF0, 8'hE2, 8'hF2, 8'hE3, 8'hF3:
        dif.dec = mk(CIT_AM_INDIRECT, `CIT_B1, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'h42, 8'h52, 8'h62:
        dif.dec = mk(CIT_AM_DIRECT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'h03, 8'h23: dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
      8'h13, 8'h33: dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_CY);
      8'h43, 8'h53, 8'h63:
        dif.dec = mk(CIT_AM_DIRECT, `CIT_B3, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'h73, 8'h83, 8'h93: dif.dec = mk(CIT_AM_CODE, `CIT_B1, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'hA3:
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
      8'hB3, 8'hC3, 8'hD3, 8'hD4:
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_CY);
      8'h04, 8'h14, 8'hC4, 8'hE4, 8'hF4:
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
      8'h24, 8'h34, 8'h94:
        dif.dec = mk(CIT_AM_IMM, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_ALL);
      8'h44, 8'h54, 8'h64, 8'h74:
        dif.dec = mk(CIT_AM_IMM, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'h84:
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C8, 1'b0, `CIT_FL_CYOV);
      8'hA4:
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C4, 1'b0, `CIT_FL_CYOV);
      8'hA5: begin
        // Unassigned code runs as a one-clock no-op
        dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
        dif.dec.illegal = 1'b1;
      end
      8'hB4: dif.dec = mk(CIT_AM_IMM, `CIT_B3, `CIT_C3, 1'b1, `CIT_FL_CY);
      8'hB5: dif.dec = mk(CIT_AM_DIRECT, `CIT_B3, `CIT_C4, 1'b1, `CIT_FL_CY);
      8'hD5: dif.dec = mk(CIT_AM_DIRECT, `CIT_B3, `CIT_C3, 1'b1, `CIT_FL_NONE);
      8'h75, 8'h85: dif.dec = mk(CIT_AM_DIRECT, `CIT_B3, `CIT_C3, 1'b0, `CIT_FL_NONE);
      8'h25, 8'h35, 8'h95:
        dif.dec = mk(CIT_AM_DIRECT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_ALL);
      8'h?5:
        dif.dec = mk(CIT_AM_DIRECT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'b1011011?: dif.dec = mk(CIT_AM_INDIRECT, `CIT_B3, `CIT_C4, 1'b1, `CIT_FL_CY);
      8'b0111011?, 8'b1000011?, 8'b1010011?:
        dif.dec = mk(CIT_AM_INDIRECT, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'b0010011?, 8'b0011011?, 8'b1001011?:
        dif.dec = mk(CIT_AM_INDIRECT, `CIT_B1, `CIT_C2, 1'b0, `CIT_FL_ALL);
      8'b????011?:
        dif.dec = mk(CIT_AM_INDIRECT, `CIT_B1, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'b10111???: dif.dec = mk(CIT_AM_REG, `CIT_B3, `CIT_C3, 1'b1, `CIT_FL_CY);
      8'b11011???: dif.dec = mk(CIT_AM_REG, `CIT_B2, `CIT_C2, 1'b1, `CIT_FL_NONE);
      8'b01111???, 8'b10001???, 8'b10101???:
        dif.dec = mk(CIT_AM_REG, `CIT_B2, `CIT_C2, 1'b0, `CIT_FL_NONE);
      8'b00101???, 8'b00111???, 8'b10011???:
        dif.dec = mk(CIT_AM_REG, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_ALL);
      8'b????1???:
        dif.dec = mk(CIT_AM_REG, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
      default: dif.dec = mk(CIT_AM_IMPLIED, `CIT_B1, `CIT_C1, 1'b0, `CIT_FL_NONE);
    endcase
  end

endmodule : cit_decode

// [logic/cit_core.sv]
//
// Contract
// - Opcodes decode exactly as the standard 8051
// - Timing counted in single system clocks only
// - Untaken conditional branch finishes one clock sooner
// - No instruction exceeds eight clocks; divide takes eight
// - 109 instructions with the documented time distribution
// - Clocks generally equal program bytes, except listed forms
// - Accumulator ALU with bank register: 1 byte, 1 clock
// - Accumulator ALU with direct byte: 2 bytes, 2 clocks
// - Indirect ALU, increment, decrement: 1 byte, 2 clocks
// - Accumulator ALU with immediate: 2 bytes, 2 clocks
// - Logic immediate-to-direct 3/3; accumulator-to-direct 2/2
// - Data pointer pair increment: 1 byte, 1 clock
// - Bank register picks R0..R7 in current bank
// - Indirect address from bank register 0 or 1
`timescale 1ns/10ps
`include "cit_regs.svh"

module cit_core (
  input wire logic clock_i, // System clock, 250 MHz
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic opcode_valid_i, // Opcode offered this cycle
  input wire logic [7:0] opcode_i, // First program byte
  input wire logic taken_i, // Branch condition met, with opcode
  input wire logic [1:0] bank_sel_i, // Register bank from status word
  output logic ready_o, // Opcode may be taken this cycle
  output logic busy_o, // An instruction is executing
  output logic done_o, // Last clock of the instruction
  output logic [1:0] bytes_o, // Program bytes of the instruction
  output logic [3:0] cycles_o, // Clocks this instruction takes
  output cit_pkg::cit_amode_t amode_o, // Operand addressing mode
  output logic [7:0] reg_addr_o, // Bank register or pointer address
  output logic [2:0] flag_mask_o, // Status word flags updated
  output logic illegal_o // Unassigned opcode seen
);
  import cit_pkg::*;

  cit_dec_if dif ();

  cit_state_t state_reg;
  logic ready_reg;
  logic done_reg;
  logic [3:0] remain_reg;
  logic accept;
  logic [3:0] eff_cycles;
  logic [3:0] run_len_reg;

  // ========================================================================
  // Decode
  assign dif.opcode = opcode_i;

  cit_decode u_decode (
    .dif (dif.decoder)
  );

  assign accept = opcode_valid_i && ready_reg;
  // Taken branch costs one extra clock over the untaken time
  assign eff_cycles = dif.dec.cycles + {3'h0, dif.dec.cond & taken_i};

  // ========================================================================
  // Clock counter: one step per system clock, no machine cycles
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      remain_reg <= `CIT_C0;
    end else if (accept) begin
      remain_reg <= eff_cycles - `CIT_C1;
    end else if (remain_reg != `CIT_C0) begin
      remain_reg <= remain_reg - `CIT_C1;
    end
  end

  // Ready returns in the last clock so instructions run back to back
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (accept) begin
      ready_reg <= (eff_cycles == `CIT_C1);
      done_reg <= (eff_cycles == `CIT_C1);
    end else begin
      ready_reg <= ready_reg || (remain_reg == `CIT_C1);
      done_reg <= (remain_reg == `CIT_C1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= CIT_ST_IDLE;
    end else begin
      unique case (state_reg)
        CIT_ST_IDLE: begin
          if (accept) begin
            state_reg <= CIT_ST_EXEC;
          end
        end
        CIT_ST_EXEC: begin
          if (done_reg && !accept) begin
            state_reg <= CIT_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Instruction attributes, held for the whole instruction
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bytes_o <= `CIT_B0;
      cycles_o <= `CIT_C0;
      amode_o <= CIT_AM_IMPLIED;
      flag_mask_o <= `CIT_FL_NONE;
      illegal_o <= 1'b0;
    end else if (accept) begin
      bytes_o <= dif.dec.bytes;
      cycles_o <= eff_cycles;
      amode_o <= dif.dec.amode;
      flag_mask_o <= dif.dec.flags;
      illegal_o <= dif.dec.illegal;
    end
  end

  // Register address within the bank selected at issue
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reg_addr_o <= `CIT_ADDR_RST;
    end else if (accept && dif.dec.amode == CIT_AM_REG) begin
      reg_addr_o <= {`CIT_ADDR_PAD, bank_sel_i, opcode_i[2:0]};
    end else if (accept && dif.dec.amode == CIT_AM_INDIRECT) begin
      // Pointer register 0 or 1 from the opcode's low bit
      reg_addr_o <= {`CIT_ADDR_PAD, bank_sel_i, `CIT_RI_PAD, opcode_i[0]};
    end
  end

  assign ready_o = ready_reg;
  assign done_o = done_reg;
  assign busy_o = (state_reg == CIT_ST_EXEC);

  // ========================================================================
  // Checks
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      run_len_reg <= `CIT_C0;
    end else if (accept) begin
      run_len_reg <= `CIT_C1;
    end else if (done_reg) begin
      run_len_reg <= `CIT_C0;
    end else if (run_len_reg != `CIT_C0) begin
      run_len_reg <= run_len_reg + `CIT_C1;
    end
  end

  property p_len_matches;
    @(posedge clock_i) disable iff (reset_i)
      done_o |-> (run_len_reg == cycles_o);
  endproperty
  a_len_matches: assert property (p_len_matches)
    else $error("instruction length differs from its clock count");

  property p_max_eight;
    @(posedge clock_i) disable iff (reset_i)
      busy_o |-> (run_len_reg <= `CIT_MAX_CYC);
  endproperty
  a_max_eight: assert property (p_max_eight)
    else $error("instruction ran past eight clocks");

  property p_nop_single;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h00) |=> done_o && busy_o;
  endproperty
  a_nop_single: assert property (p_nop_single)
    else $error("no-op did not finish in one clock");

  property p_branch_gap;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h40 && !taken_i) |=> !done_o ##1 done_o;
  endproperty
  a_branch_gap: assert property (p_branch_gap)
    else $error("untaken carry branch not two clocks");

  property p_branch_taken;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h40 && taken_i) |=> !done_o [*2] ##1 done_o;
  endproperty
  a_branch_taken: assert property (p_branch_taken)
    else $error("taken carry branch not three clocks");

  property p_alu_reg;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i[7:3] == 5'b00101) |=> done_o && bytes_o == `CIT_B1;
  endproperty
  a_alu_reg: assert property (p_alu_reg)
    else $error("add with bank register not one byte one clock");

  property p_alu_direct;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h55) |=> (!done_o && bytes_o == `CIT_B2) ##1 done_o;
  endproperty
  a_alu_direct: assert property (p_alu_direct)
    else $error("and with direct byte not two clocks");

  property p_alu_ind;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i[7:1] == 7'b0000011) |=> (!done_o && bytes_o == `CIT_B1) ##1 done_o;
  endproperty
  a_alu_ind: assert property (p_alu_ind)
    else $error("indirect increment not one byte two clocks");

  property p_alu_imm;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h24) |=> (!done_o && bytes_o == `CIT_B2) ##1 done_o;
  endproperty
  a_alu_imm: assert property (p_alu_imm)
    else $error("add immediate not two clocks");

  property p_logic_dir_imm;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h63) |=> (!done_o && bytes_o == `CIT_B3) [*2] ##1 done_o;
  endproperty
  a_logic_dir_imm: assert property (p_logic_dir_imm)
    else $error("xor immediate to direct not three clocks");

  property p_data_pointer_pair_inc;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'hA3) |=> done_o && bytes_o == `CIT_B1;
  endproperty
  a_data_pointer_pair_inc: assert property (p_data_pointer_pair_inc)
    else $error("pointer increment not one clock");

  property p_divide;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i == 8'h84) |=> !done_o [*7] ##1 done_o;
  endproperty
  a_divide: assert property (p_divide)
    else $error("divide not eight clocks");

  property p_bank_addr;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i[7:3] == 5'b11101)
        |=> reg_addr_o == {`CIT_ADDR_PAD, $past(bank_sel_i), $past(opcode_i[2:0])};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("bank register address wrong");

  property p_ind_addr;
    @(posedge clock_i) disable iff (reset_i)
      (accept && opcode_i[7:1] == 7'b1110011)
        |=> reg_addr_o[7:1] == {`CIT_ADDR_PAD, $past(bank_sel_i), `CIT_RI_PAD};
  endproperty
  a_ind_addr: assert property (p_ind_addr)
    else $error("indirect pointer not register 0 or 1");

endmodule : cit_core

// [testbench/cit_prog_mem.sv]
`timescale 1ns/10ps

// ==========================================================================
// Program memory: offers queued opcodes and holds each until it is taken
module cit_prog_mem (
  input wire logic clock_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic ready_i, // Core can take an opcode
  input wire logic slow_i, // Idle one cycle after every fetch
  output logic valid_o, // Opcode offered
  output logic [7:0] opcode_o, // First program byte
  output logic taken_o, // Branch condition met
  output logic [1:0] bank_o // Register bank select
);
  logic [10:0] fifo_q [$];
  logic idle;

  function automatic void push(input logic [7:0] op, input logic tk, input logic [1:0] bank);
    fifo_q.push_back({op, tk, bank});
  endfunction : push

  // One process owns every output, so reset puts the lines to a known idle
  always @(posedge clock_i) begin
    if (reset_i) begin
      idle = 1'b0;
    end else if (valid_o && ready_i) begin
      void'(fifo_q.pop_front());
      idle = slow_i;
    end else begin
      idle = 1'b0;
    end
    if (reset_i) begin
      valid_o <= 1'b0;
      opcode_o <= 8'h00;
      taken_o <= 1'b0;
      bank_o <= 2'h0;
    end else if (fifo_q.size() > 0 && !idle) begin
      valid_o <= 1'b1;
      {opcode_o, taken_o, bank_o} <= fifo_q[0];
    end else begin
      // Stale lines toggle so a late sample cannot pass by luck
      valid_o <= 1'b0;
      opcode_o <= ~opcode_o;
      taken_o <= ~taken_o;
      bank_o <= ~bank_o;
    end
  end
endmodule : cit_prog_mem

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "cit_regs.svh"

module tb_top;
  import cit_pkg::*;

  // ==========================================================================
  // Clock, reset and wiring
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic slow = 1'b0;
  logic opcode_valid_i, taken_i, ready_o, busy_o, done_o, illegal_o;
  logic [7:0] opcode_i, reg_addr_o;
  logic [1:0] bank_sel_i, bytes_o;
  logic [3:0] cycles_o;
  logic [2:0] flag_mask_o;
  cit_amode_t amode_o;
  int num_errors = 0;
  int compares = 0;
  int cycle_cnt = 0;
  logic [3:0] hi [6] = '{4'h2, 4'h3, 4'h9, 4'h5, 4'h4, 4'h6};
  logic [15:0] br [13] = '{16'h4022, 16'h5022, 16'h6022, 16'h7022, 16'h2033, 16'h3033,
    16'h1033, 16'hB534, 16'hB433, 16'hB833, 16'hB634, 16'hD822, 16'hD533};
  logic [15:0] un [16] = '{16'h0011, 16'h1123, 16'h0234, 16'h1234, 16'h2215, 16'h3215,
    16'h8023, 16'h9033, 16'h7313, 16'h9313, 16'hE013, 16'hE213, 16'hC022, 16'h8533,
    16'hA622, 16'hE411};

  always #2 clock_i = ~clock_i;

  cit_prog_mem u_mem (.clock_i(clock_i), .reset_i(reset_i), .ready_i(ready_o), .slow_i(slow),
    .valid_o(opcode_valid_i), .opcode_o(opcode_i), .taken_o(taken_i), .bank_o(bank_sel_i));

  cit_core DUT (.clock_i(clock_i), .reset_i(reset_i), .opcode_valid_i(opcode_valid_i),
    .opcode_i(opcode_i), .taken_i(taken_i), .bank_sel_i(bank_sel_i), .ready_o(ready_o),
    .busy_o(busy_o), .done_o(done_o), .bytes_o(bytes_o), .cycles_o(cycles_o),
    .amode_o(amode_o), .reg_addr_o(reg_addr_o), .flag_mask_o(flag_mask_o),
    .illegal_o(illegal_o));

  // ==========================================================================
  // Shared checks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  function automatic logic [2:0] fl(input int i);
    return (i < 3) ? `CIT_FL_ALL : `CIT_FL_NONE;
  endfunction : fl

  task automatic chk_idle();
    cmp("ready_busy_done", 8'h04, {5'h0, ready_o, busy_o, done_o});
    cmp("bytes_cycles", 8'h00, {2'h0, bytes_o, cycles_o});
    cmp("amode", {5'h0, CIT_AM_IMPLIED}, {5'h0, amode_o});
    cmp("reg_addr", 8'h00, reg_addr_o);
    cmp("flags_illegal", 8'h00, {4'h0, flag_mask_o, illegal_o});
  endtask : chk_idle

  // One instruction: bc = {bytes, clocks}; chk picks amode and reg_addr;
  // mode 0 queues it, 1 is preloaded, 2 is preloaded and must go back to back
  task automatic exec(input logic [7:0] op, input logic [2:0] tkb, input logic [7:0] bc,
      input logic [2:0] f, input cit_amode_t am, input logic [7:0] ra, input logic [1:0] chk,
      input logic [1:0] mode);
    int k;
    int n;
    k = 0;
    n = 0;
    if (mode == 2'h0) u_mem.push(op, tkb[2], tkb[1:0]);
    while (!(opcode_valid_i === 1'b1 && ready_o === 1'b1) && k < 20) begin
      @(negedge clock_i);
      k++;
    end
    if (mode == 2'h2) cmp("accept_wait", 8'h00, 8'(k));
    do begin
      @(negedge clock_i);
      n++;
      if (n == 1 && bc[3:0] > 4'h1) cmp("ready_mid", 8'h00, {7'h0, ready_o});
    end while (done_o !== 1'b1 && n < 10);
    cmp("clocks", {4'h0, bc[3:0]}, 8'(n));
    cmp("cycles_o", {4'h0, bc[3:0]}, {4'h0, cycles_o});
    cmp("bytes_o", {6'h0, bc[5:4]}, {6'h0, bytes_o});
    cmp("flags", {5'h0, f}, {5'h0, flag_mask_o});
    cmp("illegal", {7'h0, op == 8'hA5}, {7'h0, illegal_o});
    cmp("busy_ready", 8'h03, {6'h0, busy_o, ready_o});
    if (chk[0]) cmp("amode", {5'h0, am}, {5'h0, amode_o});
    if (chk[1]) cmp("reg_addr", ra, reg_addr_o);
  endtask : exec

  // ==========================================================================
  // Scenarios
  task automatic t_reg();
    for (int i = 0; i < 6; i++) begin
      for (int n = 0; n < 8; n++) begin
        exec({hi[i], 1'b1, 3'(n)}, {1'b0, 2'(n)}, 8'h11, fl(i), CIT_AM_REG,
          {3'h0, 2'(n), 3'(n)}, 2'h3, 2'h0);
      end
    end
    $display("test bank register done");
  endtask : t_reg

  task automatic t_dir_imm();
    for (int i = 0; i < 6; i++) begin
      exec({hi[i], 4'h5}, 3'h0, 8'h22, fl(i), CIT_AM_DIRECT, 8'h00, 2'h1, 2'h0);
      exec({hi[i], 4'h4}, 3'h4, 8'h22, fl(i), CIT_AM_IMM, 8'h00, 2'h1, 2'h0);
    end
    $display("test direct and immediate done");
  endtask : t_dir_imm

  task automatic t_ind();
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 2; j++) begin
        exec({hi[i], 3'h3, 1'(j)}, {1'b0, 2'(i)}, 8'h12, fl(i), CIT_AM_INDIRECT,
          {3'h0, 2'(i), 2'h0, 1'(j)}, 2'h3, 2'h0);
      end
    end
    for (int k = 0; k < 4; k++) begin
      exec({3'h0, 1'(k >> 1), 3'h3, 1'(k)}, {1'b0, 2'(k)}, 8'h12, `CIT_FL_NONE,
        CIT_AM_INDIRECT, {3'h0, 2'(k), 2'h0, 1'(k)}, 2'h3, 2'h0);
    end
    $display("test indirect done");
  endtask : t_ind

  task automatic t_logic_dir();
    for (int i = 3; i < 6; i++) begin
      exec({hi[i], 4'h2}, 3'h0, 8'h22, `CIT_FL_NONE, CIT_AM_DIRECT, 8'h00, 2'h0, 2'h0);
      exec({hi[i], 4'h3}, 3'h0, 8'h33, `CIT_FL_NONE, CIT_AM_DIRECT, 8'h00, 2'h0, 2'h0);
    end
    $display("test logic to direct done");
  endtask : t_logic_dir

  task automatic t_misc();
    exec(8'hA3, 3'h0, 8'h11, `CIT_FL_NONE, CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
    exec(8'hA4, 3'h0, 8'h14, `CIT_FL_CYOV, CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
    exec(8'h84, 3'h0, 8'h18, `CIT_FL_CYOV, CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
    exec(8'hA5, 3'h0, 8'h11, `CIT_FL_NONE, CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
    $display("test multiply divide pointer done");
  endtask : t_misc

  task automatic t_branch();
    for (int e = 0; e < 13; e++) begin
      for (int t = 0; t < 2; t++) begin
        exec(br[e][15:8], {1'(t), 2'h1}, br[e][7:0] + 8'(t),
          (br[e][15:12] == 4'hB) ? `CIT_FL_CY : `CIT_FL_NONE,
          CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
      end
    end
    $display("test conditional branch done");
  endtask : t_branch

  task automatic t_uncond();
    for (int e = 0; e < 16; e++) begin
      exec(un[e][15:8], 3'h0, un[e][7:0], `CIT_FL_NONE, CIT_AM_IMPLIED, 8'h00, 2'h0,
        2'h0);
    end
    exec(8'hEB, 3'h2, 8'h11, `CIT_FL_NONE, CIT_AM_REG, 8'h13, 2'h3, 2'h0);
    exec(8'hE7, 3'h1, 8'h12, `CIT_FL_NONE, CIT_AM_INDIRECT, 8'h09, 2'h3, 2'h0);
    $display("test unconditional and moves done");
  endtask : t_uncond

  task automatic t_b2b();
    u_mem.push(8'h24, 1'b0, 2'h0);
    u_mem.push(8'h2B, 1'b0, 2'h2);
    u_mem.push(8'h84, 1'b0, 2'h1);
    exec(8'h24, 3'h0, 8'h22, `CIT_FL_ALL, CIT_AM_IMM, 8'h00, 2'h1, 2'h1);
    exec(8'h2B, 3'h2, 8'h11, `CIT_FL_ALL, CIT_AM_REG, 8'h13, 2'h3, 2'h2);
    // Divide is no register form, so the last register address stays
    exec(8'h84, 3'h1, 8'h18, `CIT_FL_CYOV, CIT_AM_IMPLIED, 8'h13, 2'h2, 2'h2);
    @(posedge clock_i);
    slow <= 1'b1;
    exec(8'h25, 3'h0, 8'h22, `CIT_FL_ALL, CIT_AM_DIRECT, 8'h00, 2'h1, 2'h0);
    exec(8'h37, 3'h3, 8'h12, `CIT_FL_ALL, CIT_AM_INDIRECT, 8'h19, 2'h3, 2'h0);
    @(posedge clock_i);
    slow <= 1'b0;
    $display("test back to back and slow fetch done");
  endtask : t_b2b

  task automatic t_reset();
    // Reset lands in the middle of a divide
    u_mem.push(8'h84, 1'b0, 2'h0);
    repeat (4) @(negedge clock_i);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk_idle();
    // Core must take work again right after the mid-run reset
    exec(8'h00, 3'h0, 8'h11, `CIT_FL_NONE, CIT_AM_IMPLIED, 8'h00, 2'h0, 2'h0);
    $display("test reset mid run done");
  endtask : t_reset

  // ==========================================================================
  // Run control
  always @(posedge clock_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 5000) begin
      num_errors++;
      $display("[ERR] run_time expected below 5000 cycles seen %0d", cycle_cnt);
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk_idle();
    t_reg();
    t_dir_imm();
    t_ind();
    t_logic_dir();
    t_misc();
    t_branch();
    t_uncond();
    t_b2b();
    t_reset();
    end_sim();
  end
endmodule : tb_top
